// [core/tct_pkg.sv]
// package: constants for the thermal clock throttle
package tct_pkg;
   localparam int CLK_MHZ = 100;
   // longest clock-off time in ns, rounded down to cycles
   localparam int OFF_MAX_NS = 3000;
   localparam int OFF_MAX_CYC = (OFF_MAX_NS * CLK_MHZ) / 1000;
   // modulation period of eight slots; slot length fits the off limit
   localparam int SLOT_CYC = 32;
   localparam logic [7:0] SLOT_LAST = 8'h1f;
   // factory throttle duty: 4 of 8 slots on (50 percent)
   localparam logic [2:0] FACTORY_ON_SLOTS = 3'h4;
   // hysteresis hold time in ns and cycles
   localparam int HYST_NS = 20000;
   localparam int HYST_CYC = (HYST_NS * CLK_MHZ) / 1000;
   localparam int HYST_W = 12;
   // clock-modulation control register fields
   localparam int CMC_WIDTH = 64;
   localparam int CMC_EN_BIT = 4;
   localparam int CMC_DUTY_LSB = 1;
   localparam int CMC_DUTY_MSB = 3;
   localparam logic [63:0] CMC_RESET = 64'h0;
   // bits of the device's own configuration word beside the register
   localparam int CFG_HOT_IRQ_BIT = 0;
   localparam int CFG_COOL_IRQ_BIT = 1;
   typedef enum logic [1:0] {
      TCT_IDLE = 2'b00,
      TCT_HOT  = 2'b01,
      TCT_HYST = 2'b10
   } tct_state_t;
endpackage : tct_pkg

// [core/tct_sync.sv]
// two-flop synchroniser for an asynchronous level
`timescale 1ns/1ps
`default_nettype none
module tct_sync (
   input  wire logic sys_clk,
   input  wire logic rst_n,
   input  wire logic asyncIn,
   output logic      syncOut
);
   logic meta_q;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q  <= 1'b1;
         syncOut <= 1'b1;
      end else begin
         meta_q  <= asyncIn;
         syncOut <= meta_q;
      end
   end
endmodule : tct_sync
`default_nettype wire

// [core/tct_throttle.sv]
// thermal clock throttle: trip detection, modulation and shutdown
// Summary of operation
// - monitor enabled and hot: throttle core clocks
// - thermal throttle uses fixed factory duty
// - no clock-off stretch beyond three microseconds
// - latch interrupts, service only when clock on
// - release only after cool and hysteresis expiry
// - trip threshold fixed, not software visible
// - control bit 4 starts software modulation
// - bits 3:1 set duty in eighths
// - factory duty overrides software duty when hot
// - die-hot output asserted at trip point
// - optional interrupt on die-hot edges
// - force input throttles, with monitor enabled, until platform releases
// - force input synchronised before use
// - force never asserts die-hot output
// - catastrophic heat drives shutdown output
// - shutdown independent of activity, no bus
`timescale 1ns/1ps
`default_nettype none
module tct_throttle (
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic        monitorEnable,
   input  wire logic        dieTripHot,
   input  wire logic        dieCatastrophic,
   input  wire logic        force_throttle_in_n,
   input  wire logic        cmcWrite,
   input  wire logic [63:0] cmcWdata,
   output logic      [63:0] cmcRdata,
   input  wire logic        cfgWrite,
   input  wire logic [1:0]  cfgWdata,
   input  wire logic        irqReqIn,
   input  wire logic        irqTaken,
   output logic             irqPending,
   output logic             irqServe,
   output logic             thermIrq,
   output logic             coreClkEn,
   output logic             throttleActive,
   output logic             die_hot_out_n,
   output logic             thermal_shutdown_out_n
);
   import tct_pkg::*;

   logic [63:0]     cmc_q;
   logic [1:0]      cfg_q;
   tct_state_t      state_q;
   tct_state_t      state_d;
   logic [HYST_W-1:0] hyst_q;
   logic [7:0]      slotCnt_q;
   logic [2:0]      slotIdx_q;
   logic            hot_q;
   logic            clkOn_q;
   logic            irqPend_q;
   logic            shut_q;
   logic            forceSync_n;
   logic            forceAct;
   logic            tccReq;
   logic            swMod;
   logic [2:0]      swDuty;
   logic [2:0]      onSlots;
   logic            modulate;
   logic            slotEnd;
   logic            slotOn;
   logic            hystDone;
   logic [HYST_W-1:0] coolRun_q;
   logic [8:0]      offRun_q;

   tct_sync u_force_sync (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .asyncIn (force_throttle_in_n),
      .syncOut (forceSync_n)
   );

   assign forceAct = ~forceSync_n;
   // trip point is an internal input only
   assign tccReq   = monitorEnable & (dieTripHot | forceAct);
   assign swMod    = cmc_q[CMC_EN_BIT];
   assign swDuty   = cmc_q[CMC_DUTY_MSB:CMC_DUTY_LSB];
   assign throttleActive = (state_q != TCT_IDLE);
   assign modulate = throttleActive | swMod;
   // factory duty wins when engaged
   // duty code zero is treated as one eighth so the core never halts
   assign onSlots  = throttleActive ? FACTORY_ON_SLOTS
                   : ((swDuty == 3'h0) ? 3'h1 : swDuty);
   assign slotEnd  = (slotCnt_q == SLOT_LAST);
   assign slotOn   = (slotIdx_q < onSlots);
   assign hystDone = (hyst_q == HYST_W'(HYST_CYC - 1));
   assign cmcRdata = cmc_q;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cmc_q <= CMC_RESET;
         cfg_q <= 2'h0;
      end else begin
         if (cmcWrite) cmc_q <= cmcWdata;
         if (cfgWrite) cfg_q <= cfgWdata;
      end
   end

   always_comb begin
      state_d = state_q;
      case (state_q)
         TCT_IDLE: if (tccReq) state_d = TCT_HOT;
         TCT_HOT:  if (!tccReq) state_d = TCT_HYST;
         TCT_HYST: begin
            if (tccReq) state_d = TCT_HOT;
            else if (hystDone) state_d = TCT_IDLE;
         end
         default:  state_d = TCT_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= TCT_IDLE;
         hyst_q  <= '0;
      end else begin
         state_q <= state_d;
         if (state_q == TCT_HYST && state_d == TCT_HYST)
            hyst_q <= hyst_q + HYST_W'(1);
         else
            hyst_q <= '0;
      end
   end

   // slots short enough that off time stays under limit
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         slotCnt_q <= 8'h0;
         slotIdx_q <= 3'h0;
         clkOn_q   <= 1'b1;
      end else if (!modulate) begin
         slotCnt_q <= 8'h0;
         slotIdx_q <= 3'h0;
         clkOn_q   <= 1'b1;
      end else begin
         slotCnt_q <= slotEnd ? 8'h0 : slotCnt_q + 8'h1;
         if (slotEnd) slotIdx_q <= slotIdx_q + 3'h1;
         clkOn_q   <= slotOn;
      end
   end
   assign coreClkEn = clkOn_q;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         offRun_q <= '0;
      else if (clkOn_q)
         offRun_q <= '0;
      else if (offRun_q != '1)
         offRun_q <= offRun_q + 9'h1;
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         coolRun_q <= '0;
      else if (tccReq)
         coolRun_q <= '0;
      else if (coolRun_q != '1)
         coolRun_q <= coolRun_q + HYST_W'(1);
   end

   // latch requests, serve when clocks run
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         irqPend_q <= 1'b0;
      else if (irqReqIn)
         irqPend_q <= 1'b1;
      else if (irqTaken && clkOn_q)
         irqPend_q <= 1'b0;
   end
   assign irqPending = irqPend_q;
   assign irqServe   = irqPend_q & clkOn_q;

   // force is not part of die-hot
   // pure hardware path, no bus traffic
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         hot_q  <= 1'b0;
         shut_q <= 1'b0;
      end else begin
         hot_q  <= dieTripHot;
         if (dieCatastrophic) shut_q <= 1'b1;
      end
   end
   assign die_hot_out_n          = ~hot_q;
   assign thermal_shutdown_out_n = ~shut_q;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         thermIrq <= 1'b0;
      else
         thermIrq <= (cfg_q[CFG_HOT_IRQ_BIT] & dieTripHot & ~hot_q)
                   | (cfg_q[CFG_COOL_IRQ_BIT] & ~dieTripHot & hot_q);
   end

   // trip with monitor on engages throttle
   property p_engage;
      @(posedge sys_clk) disable iff (!rst_n)
      (monitorEnable && dieTripHot) |=> throttleActive;
   endproperty
   a_engage: assert property (p_engage) else $error("no throttle");

   property p_factory;
      @(posedge sys_clk) disable iff (!rst_n)
      throttleActive |=> coreClkEn == ($past(slotIdx_q) < FACTORY_ON_SLOTS);
   endproperty
   a_factory: assert property (p_factory) else $error("duty");

   property p_offmax;
      @(posedge sys_clk) disable iff (!rst_n)
      $fell(coreClkEn) && throttleActive |-> ##[1:150] coreClkEn;
   endproperty
   a_offmax: assert property (p_offmax) else $error("off long");

   property p_serve;
      @(posedge sys_clk) disable iff (!rst_n)
      (irqPending && !coreClkEn) |=> irqPending;
   endproperty
   a_serve: assert property (p_serve) else $error("serve off");

   property p_hyst;
      @(posedge sys_clk) disable iff (!rst_n)
      (state_q == TCT_HOT && !tccReq) |=> throttleActive [*8];
   endproperty
   a_hyst: assert property (p_hyst) else $error("early drop");

   property p_hot;
      @(posedge sys_clk) disable iff (!rst_n)
      dieTripHot |=> !die_hot_out_n;
   endproperty
   a_hot: assert property (p_hot) else $error("die-hot");

   property p_force;
      @(posedge sys_clk) disable iff (!rst_n)
      (!dieTripHot) |=> die_hot_out_n;
   endproperty
   a_force: assert property (p_force) else $error("force hot");

   property p_shut;
      @(posedge sys_clk) disable iff (!rst_n)
      dieCatastrophic |=> !thermal_shutdown_out_n;
   endproperty
   a_shut: assert property (p_shut) else $error("no shutdown");

   property p_stick;
      @(posedge sys_clk) disable iff (!rst_n)
      !thermal_shutdown_out_n |=> !thermal_shutdown_out_n;
   endproperty
   a_stick: assert property (p_stick) else $error("released");

   property p_latch;
      @(posedge sys_clk) disable iff (!rst_n)
      irqReqIn |=> irqPending;
   endproperty
   a_latch: assert property (p_latch) else $error("irq lost");

   property p_hold;
      @(posedge sys_clk) disable iff (!rst_n)
      (irqPending && !irqTaken) |=> irqPending;
   endproperty
   a_hold: assert property (p_hold) else $error("irq dropped");

   property p_cool;
      @(posedge sys_clk) disable iff (!rst_n)
      $fell(throttleActive) |-> coolRun_q >= HYST_W'(HYST_CYC);
   endproperty
   a_cool: assert property (p_cool) else $error("short hysteresis");

   property p_monoff;
      @(posedge sys_clk) disable iff (!rst_n)
      (!monitorEnable && !throttleActive) |=> !throttleActive;
   endproperty
   a_monoff: assert property (p_monoff) else $error("monitor off");

   property p_idle;
      @(posedge sys_clk) disable iff (!rst_n)
      (!throttleActive && !cmcRdata[CMC_EN_BIT]) |=> coreClkEn;
   endproperty
   a_idle: assert property (p_idle) else $error("clock stopped");

   property p_reg;
      @(posedge sys_clk) disable iff (!rst_n)
      cmcWrite |=> cmcRdata == $past(cmcWdata);
   endproperty
   a_reg: assert property (p_reg) else $error("write lost");

   property p_offrun;
      @(posedge sys_clk) disable iff (!rst_n)
      throttleActive |-> offRun_q < 9'(OFF_MAX_CYC);
   endproperty
   a_offrun: assert property (p_offrun) else $error("off too long");

   // unsynchronised use would react one or two cycles early
   property p_sync;
      @(posedge sys_clk) disable iff (!rst_n)
      (!throttleActive && !dieTripHot && $past(force_throttle_in_n, 2))
         |=> !throttleActive;
   endproperty
   a_sync: assert property (p_sync) else $error("force early");

   property p_force_eng;
      @(posedge sys_clk) disable iff (!rst_n)
      (monitorEnable && !force_throttle_in_n)
         |-> ##3 (throttleActive || !$past(monitorEnable));
   endproperty
   a_force_eng: assert property (p_force_eng) else $error("no force");

   property p_irq_hot;
      @(posedge sys_clk) disable iff (!rst_n)
      ($fell(die_hot_out_n) && $past(cfg_q[CFG_HOT_IRQ_BIT])) |-> thermIrq;
   endproperty
   a_irq_hot: assert property (p_irq_hot) else $error("no hot irq");

   property p_irq_cool;
      @(posedge sys_clk) disable iff (!rst_n)
      ($rose(die_hot_out_n) && $past(cfg_q[CFG_COOL_IRQ_BIT])) |-> thermIrq;
   endproperty
   a_irq_cool: assert property (p_irq_cool) else $error("no cool irq");

   property p_irq_edge;
      @(posedge sys_clk) disable iff (!rst_n)
      thermIrq |-> $changed(die_hot_out_n);
   endproperty
   a_irq_edge: assert property (p_irq_edge) else $error("stray irq");

   property p_shut_src;
      @(posedge sys_clk) disable iff (!rst_n)
      $fell(thermal_shutdown_out_n) |-> $past(dieCatastrophic);
   endproperty
   a_shut_src: assert property (p_shut_src) else $error("stray shut");
endmodule : tct_throttle
`default_nettype wire

// [verif/tct_platform_model.sv]
// platform model driving the force-throttle pin
`timescale 1ns/1ps
`default_nettype none
module tct_platform_model #(
   parameter int HOLD_CYC = 50000
) (
   input  wire logic sys_clk,
   input  wire logic req,
   output var logic  force_throttle_in_n
);
   initial begin
      force_throttle_in_n = 1'h1;
      forever begin
         @(posedge sys_clk iff req);
         // full width; edges kept off the clock, pin is async
         #3 force_throttle_in_n = 1'h0;
         repeat (HOLD_CYC) @(posedge sys_clk);
         #3 force_throttle_in_n = 1'h1;
      end
   end
endmodule : tct_platform_model
`default_nettype wire

// [verif/tb_top.sv]
// self-checking bench for the thermal clock throttle
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin numChecks++; if ((a) !== (e)) begin numErrors++; \
   $display("[ERR] %0t got %0h exp %0h", $time, (a), (e)); end end
module tb_top;
   import tct_pkg::*;
   logic        sys_clk = 1'h0, rst_n = 1'h0, monitorEnable = 1'h1;
   logic        dieTripHot = 1'h0, dieCatastrophic = 1'h0, fReq = 1'h0;
   logic        cmcWrite = 1'h0, cfgWrite = 1'h0, irqReqIn = 1'h0;
   logic [63:0] cmcWdata = 64'h0, cmcRdata;
   logic [1:0]  cfgWdata = 2'h3;
   logic        irqPending, irqServe, thermIrq, irqTaken = 1'h0;
   logic        throttleActive, die_hot_out_n, thermal_shutdown_out_n;
   logic        force_throttle_in_n, coreClkEn;
   int          numErrors = 0, numChecks = 0, irqCnt = 0, on, off;
   always #5 sys_clk = ~sys_clk;
   // counted at negedge, clear of the update edge
   always @(negedge sys_clk) if (thermIrq === 1'h1) irqCnt++;
   tct_throttle dut_u (.sys_clk, .rst_n, .monitorEnable, .dieTripHot,
      .dieCatastrophic, .force_throttle_in_n, .cmcWrite, .cmcWdata,
      .cmcRdata, .cfgWrite, .cfgWdata, .irqReqIn, .irqTaken, .irqPending,
      .irqServe, .thermIrq, .coreClkEn, .throttleActive, .die_hot_out_n,
      .thermal_shutdown_out_n);
   tct_platform_model plat_u (.sys_clk, .req(fReq), .force_throttle_in_n);
   task automatic step(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : step
   task automatic wrCmc(input logic [63:0] v);
      cmcWdata = v;
      cmcWrite = 1'h1;
      step(1);
      cmcWrite = 1'h0;
   endtask : wrCmc
   task automatic waitFor(input logic sel, input logic v);
      for (int i = 0; i < 2500 && (sel ? coreClkEn : throttleActive) !== v;
         i++) step(1);
   endtask : waitFor
   // settle one period, then count one whole period
   task automatic meas;
      int run = 0;
      {on, off} = '0;
      step(8 * SLOT_CYC);
      repeat (8 * SLOT_CYC) begin
         step(1);
         on += int'(coreClkEn === 1'h1);
         run = (coreClkEn === 1'h1) ? 0 : run + 1;
         off = (run > off) ? run : off;
      end
   endtask : meas
   task automatic t_hot;
      cfgWrite = 1'h1;
      step(1);
      cfgWrite = 1'h0;
      dieTripHot = 1'h1;
      step(2);
      `CHK(die_hot_out_n, 1'h0)
      `CHK(throttleActive, 1'h1)
      wrCmc(64'h12);
      meas;
      `CHK(on, int'(FACTORY_ON_SLOTS) * SLOT_CYC)
      `CHK(off <= OFF_MAX_CYC, 1'h1)
      // start of a fresh off stretch
      waitFor(1'h1, 1'h1);
      waitFor(1'h1, 1'h0);
      irqReqIn = 1'h1;
      step(1);
      irqReqIn = 1'h0;
      `CHK({irqPending, irqServe}, 2'h2)
      irqTaken = 1'h1;
      step(1);
      irqTaken = 1'h0;
      `CHK(irqPending, 1'h1)
      waitFor(1'h1, 1'h1);
      `CHK(irqServe, 1'h1)
      irqTaken = 1'h1;
      step(1);
      irqTaken = 1'h0;
      `CHK(irqPending, 1'h0)
      dieTripHot = 1'h0;
      step(HYST_CYC);
      `CHK(throttleActive, 1'h1)
      step(1);
      `CHK(throttleActive, 1'h0)
      `CHK(irqCnt, 2)
   endtask : t_hot
   task automatic t_nomon;
      int base;
      base = irqCnt;
      monitorEnable = 1'h0;
      cfgWdata = 2'h1;
      cfgWrite = 1'h1;
      step(1);
      cfgWrite = 1'h0;
      dieTripHot = 1'h1;
      step(3);
      `CHK(die_hot_out_n, 1'h0)
      `CHK(throttleActive, 1'h0)
      dieTripHot = 1'h0;
      step(3);
      `CHK(irqCnt - base, 1)
      monitorEnable = 1'h1;
   endtask : t_nomon
   task automatic t_soft;
      for (int d = 0; d < 8; d++) begin
         wrCmc(64'h10 | (64'(d) << 1));
         `CHK(cmcRdata, 64'h10 | (64'(d) << 1))
         meas;
         `CHK(on, (d == 0 ? 1 : d) * SLOT_CYC)
      end
      wrCmc(64'h0);
      meas;
      `CHK(on, 8 * SLOT_CYC)
   endtask : t_soft
   task automatic t_force;
      fReq = 1'h1;
      step(1);
      fReq = 1'h0;
      step(2);
      `CHK(throttleActive, 1'h0)
      step(1);
      `CHK(throttleActive, 1'h1)
      step(3);
      `CHK(throttleActive, 1'h1)
      `CHK(die_hot_out_n, 1'h1)
      while (force_throttle_in_n !== 1'h1) step(1);
      `CHK(throttleActive, 1'h1)
      waitFor(1'h0, 1'h0);
      `CHK(throttleActive, 1'h0)
   endtask : t_force
   task automatic t_shut;
      monitorEnable = 1'h0;
      `CHK(thermal_shutdown_out_n, 1'h1)
      dieCatastrophic = 1'h1;
      step(1);
      dieCatastrophic = 1'h0;
      step(1);
      `CHK(thermal_shutdown_out_n, 1'h0)
      step(100);
      `CHK(thermal_shutdown_out_n, 1'h0)
      rst_n = 1'h0;
      step(2);
      `CHK(thermal_shutdown_out_n, 1'h1)
      rst_n = 1'h1;
      step(2);
      `CHK(thermal_shutdown_out_n, 1'h1)
      monitorEnable = 1'h1;
   endtask : t_shut
   task automatic final_report;
      if (numErrors == 0 && numChecks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : final_report
   initial begin
      step(8);
      rst_n = 1'h1;
      step(2);
      `CHK(cmcRdata, CMC_RESET)
      t_hot;
      t_nomon;
      t_soft;
      t_force;
      t_shut;
      final_report;
   end
   // run is near 60k cycles, mostly the force hold
   initial begin
      #700000;
      numErrors++;
      final_report;
   end
endmodule : tb_top
`default_nettype wire
